/* File: hw/sslpq_ctrl.sv */
`timescale 1ns/1ps
module sslpq_ctrl
    import sslpq_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic sleep_request_i,
    input wire logic select_one_n_i,
    input wire logic select_two_i,
    input wire logic select_three_n_i,
    input wire logic cpu_addr_strobe_n_i,
    input wire logic ctl_addr_strobe_n_i,
    input wire logic burst_step_n_i,
    input wire logic linear_order_n_i,
    input wire logic write_enable_n_i,
    input wire logic all_byte_write_n_i,
    input wire logic [LANES-1:0] lane_write_n_i,
    input wire logic output_enable_n_i,
    output logic chip_sel_o,
    output logic write_o,
    output logic [LANES-1:0] lane_write_o,
    output logic dq_oe_n_o,
    output logic clk_run_o,
    output logic asleep_o,
    output logic read_valid_o,
    output logic burst_linear_o
);
    sslpq_state_e state_r;
    sslpq_state_e state_nxt;
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic strobe;
    logic en_dec;
    logic wr_dec;
    logic [LANES-1:0] lanes_dec;
    logic awake;
    logic sel_nxt;
    logic wr_nxt;
    logic [LANES-1:0] lanes_nxt;

    assign strobe = ~cpu_addr_strobe_n_i | ~ctl_addr_strobe_n_i;
    assign en_dec = ~select_one_n_i & select_two_i & ~select_three_n_i;
    assign wr_dec = ~all_byte_write_n_i | (~write_enable_n_i & |(~lane_write_n_i));
    assign awake = (state_r == SSLPQ_AWAKE);

    always_comb begin
        if (!all_byte_write_n_i) begin
            lanes_dec = LANES_ALL;
        end else if (!write_enable_n_i) begin
            lanes_dec = ~lane_write_n_i;
        end else begin
            lanes_dec = LANES_NONE;
        end
    end

    // sleep sequencing
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            SSLPQ_AWAKE: begin
                if (sleep_request_i) begin
                    state_nxt = SSLPQ_ENTER;
                    cnt_nxt = ENTRY_CYC - 2'h1;
                end
            end
            SSLPQ_ENTER: begin
                if (!sleep_request_i) begin
                    state_nxt = SSLPQ_RECOVER;
                    cnt_nxt = RECOVER_CYC - 2'h1;
                end else if (cnt_r <= 2'h1) begin
                    state_nxt = SSLPQ_SLEEP;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            SSLPQ_SLEEP: begin
                if (!sleep_request_i) begin
                    state_nxt = SSLPQ_RECOVER;
                    cnt_nxt = RECOVER_CYC - 2'h1;
                end
            end
            SSLPQ_RECOVER: begin
                // a fresh request during recovery goes straight back toward sleep
                if (sleep_request_i) begin
                    state_nxt = SSLPQ_ENTER;
                    cnt_nxt = ENTRY_CYC - 2'h1;
                end else if (cnt_r <= 2'h1) begin
                    state_nxt = SSLPQ_AWAKE;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            default: begin
                state_nxt = SSLPQ_AWAKE;
                cnt_nxt = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= SSLPQ_AWAKE;
            cnt_r <= CNT_RST;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // cycle qualification; no new cycle outside the awake state
    always_comb begin
        sel_nxt = chip_sel_o;
        wr_nxt = write_o;
        lanes_nxt = lane_write_o;
        // dropping on the first request edge keeps stale reads from looking valid
        if (state_nxt != SSLPQ_AWAKE || !awake) begin
            sel_nxt = 1'b0;
            wr_nxt = 1'b0;
            lanes_nxt = LANES_NONE;
        end else if (strobe) begin
            sel_nxt = en_dec;
            wr_nxt = en_dec & wr_dec;
            lanes_nxt = en_dec ? lanes_dec : LANES_NONE;
        end else if (chip_sel_o && !burst_step_n_i) begin
            // burst continuation requalifies the write on each beat
            wr_nxt = wr_dec;
            lanes_nxt = lanes_dec;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chip_sel_o <= 1'b0;
            write_o <= 1'b0;
            lane_write_o <= LANES_NONE;
        end else begin
            chip_sel_o <= sel_nxt;
            write_o <= wr_nxt;
            lane_write_o <= lanes_nxt;
        end
    end

    // output enable has no say during a write, so drivers stay off
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dq_oe_n_o <= 1'b1;
        end else begin
            dq_oe_n_o <= ~(sel_nxt & ~wr_nxt & ~output_enable_n_i);
        end
    end

    // internal clock tree runs only while not asleep
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_run_o <= 1'b1;
            asleep_o <= 1'b0;
        end else begin
            clk_run_o <= (state_nxt != SSLPQ_SLEEP);
            asleep_o <= (state_nxt == SSLPQ_SLEEP);
        end
    end

    // read data flagged unreliable from request until fully awake again
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            read_valid_o <= 1'b0;
            burst_linear_o <= 1'b0;
        end else begin
            read_valid_o <= sel_nxt & ~wr_nxt & ~sleep_request_i & (state_nxt == SSLPQ_AWAKE);
            // order pin is static; only sampled to hand to the burst counter
            burst_linear_o <= ~linear_order_n_i;
        end
    end

    AST_WRITE_DECODE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && sleep_request_i == 1'b0 && strobe && en_dec) |=> (write_o == $past(wr_dec)))
        else $error("write qualification mismatch");

    AST_LANE_DECODE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && !sleep_request_i && strobe && en_dec && !all_byte_write_n_i) |=> (lane_write_o == LANES_ALL))
        else $error("all byte write did not select every lane");

    AST_ENABLE_DECODE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && !sleep_request_i && strobe) |=> (chip_sel_o == $past(en_dec)))
        else $error("chip enable decode mismatch");

    AST_OE_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (chip_sel_o && write_o) |-> dq_oe_n_o)
        else $error("data drivers on during a write");

    AST_SLEEP_ENTRY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && sleep_request_i) ##1 sleep_request_i |=> (asleep_o && !chip_sel_o))
        else $error("sleep not reached deselected after two cycles");

    AST_CLOCK_GATED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        asleep_o |-> (!clk_run_o && state_r == SSLPQ_SLEEP))
        else $error("internal clock running in sleep");

    AST_ASLEEP_IDLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (asleep_o && strobe) |=> (!chip_sel_o && !write_o && lane_write_o == LANES_NONE))
        else $error("access performed while asleep");

    AST_RECOVER_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        $fell(asleep_o) |-> (!chip_sel_o && !write_o) [*2])
        else $error("access during recovery window");

    AST_SLEEP_DESELECT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && sleep_request_i) |=> (!chip_sel_o && !write_o && !read_valid_o))
        else $error("selection kept after sleep request");

    AST_SLEEP_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_r != SSLPQ_AWAKE) |=> (!chip_sel_o && !write_o && lane_write_o == LANES_NONE))
        else $error("cycle taken outside the awake state");

    AST_OE_HELD_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && !sleep_request_i && !strobe && burst_step_n_i && write_o) |=> (write_o && dq_oe_n_o))
        else $error("write dropped or drivers on while output enable moved");

    AST_BURST_REQUAL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && !sleep_request_i && !strobe && chip_sel_o && !burst_step_n_i) |=> (write_o == $past(wr_dec)))
        else $error("burst beat write qualification mismatch");

    AST_NO_WRITE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (awake && !sleep_request_i && strobe && all_byte_write_n_i && write_enable_n_i)
        |=> (!write_o && lane_write_o == LANES_NONE))
        else $error("write flagged with write inputs idle");
endmodule : sslpq_ctrl

/* File: hw/sslpq_pkg.sv */
package sslpq_pkg;
    localparam int LANES = 4;
    localparam int CLK_PERIOD_NS = 10;
    // entry is a longest time, recovery a least time, both two clock periods
    localparam int SLEEP_ENTRY_NS = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_RECOVER_NS = 2 * CLK_PERIOD_NS;
    localparam int ENTRY_CYC_I = (SLEEP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 : (SLEEP_ENTRY_NS / CLK_PERIOD_NS);
    localparam int RECOVER_CYC_I = (SLEEP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] ENTRY_CYC = ENTRY_CYC_I[1:0];
    localparam logic [1:0] RECOVER_CYC = RECOVER_CYC_I[1:0];
    localparam logic [1:0] CNT_RST = 2'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hf;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;

    typedef enum logic [1:0] {
        SSLPQ_AWAKE,
        SSLPQ_ENTER,
        SSLPQ_SLEEP,
        SSLPQ_RECOVER
    } sslpq_state_e;
endpackage : sslpq_pkg

/* File: dv/sslpq_master.sv */
`timescale 1ns/1ps
module sslpq_master
    import sslpq_pkg::*;
(
    input wire logic clock_i,
    output logic req_o,
    output logic [2:0] sel_o,
    output logic st_n_o,
    output logic we_n_o,
    output logic ab_n_o,
    output logic [LANES-1:0] ln_n_o,
    output logic oe_n_o,
    output logic ps_n_o,
    output logic adv_n_o,
    output logic lo_n_o
);
    initial begin
        {ps_n_o, adv_n_o, lo_n_o} = 3'h6;
        req_o = 1'b0;
        sel_o = 3'h0;
        {st_n_o, we_n_o, ab_n_o, oe_n_o} = 4'hf;
        ln_n_o = LANES_ALL;
    end
    // entered at a falling edge, leaves at the next one
    task automatic cyc(input logic [2:0] s, input logic st, input logic we, input logic ab,
                       input logic [LANES-1:0] ln, input logic oe);
        {sel_o, st_n_o, we_n_o, ab_n_o, ln_n_o, oe_n_o} = {s, st, we, ab, ln, oe};
        @(negedge clock_i);
    endtask : cyc
    // cpu strobe and burst step, taken with the next cyc call
    task automatic side(input logic p, input logic a);
        {ps_n_o, adv_n_o} = {p, a};
    endtask : side
    // callers keep strobes and writes idle around this
    task automatic zz(input logic r);
        req_o = r;
        @(negedge clock_i);
    endtask : zz
endmodule : sslpq_master

/* File: dv/sync_sram_sleep_cycle_qualify_bench.sv */
`timescale 1ns/1ps
module sync_sram_sleep_cycle_qualify_bench
    import sslpq_pkg::*;
;
    logic clk, rst_n, req, st, we, ab, oe, cs, wr, oen, run, slp, rv, lin, ps, burst_step_n, lo;
    logic [2:0] sel;
    logic [LANES-1:0] ln, lw;
    int mismatches = 0;
    int comparisons = 0;
    sslpq_master m (.clock_i(clk), .req_o(req), .sel_o(sel), .st_n_o(st), .we_n_o(we),
        .ab_n_o(ab), .ln_n_o(ln), .oe_n_o(oe), .ps_n_o(ps), .adv_n_o(burst_step_n), .lo_n_o(lo));
    // master holds non-burst levels except in the burst test; order stays fixed
    sslpq_ctrl uut (.clock_i(clk), .rst_n_i(rst_n), .sleep_request_i(req),
        .select_one_n_i(sel[2]), .select_two_i(sel[1]), .select_three_n_i(sel[0]),
        .cpu_addr_strobe_n_i(ps), .ctl_addr_strobe_n_i(st), .burst_step_n_i(burst_step_n),
        .linear_order_n_i(lo), .write_enable_n_i(we), .all_byte_write_n_i(ab),
        .lane_write_n_i(ln), .output_enable_n_i(oe), .chip_sel_o(cs), .write_o(wr),
        .lane_write_o(lw), .dq_oe_n_o(oen), .clk_run_o(run), .asleep_o(slp),
        .read_valid_o(rv), .burst_linear_o(lin));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk4(input string n, input logic [LANES-1:0] e, input logic [LANES-1:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk4
    task automatic chk1(input string n, input logic e, input logic g);
        chk4(n, {3'h0, e}, {3'h0, g});
    endtask : chk1
    task automatic t_write;
        m.cyc(3'h2, 1'b0, 1'b1, 1'b0, LANES_NONE, 1'b1);
        chk1("write", 1'b1, wr);
        chk4("lanes", LANES_ALL, lw);
        chk1("oe", 1'b1, oen);
        // output enable dropped while the write still stands
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b0);
        chk1("write", 1'b1, wr);
        chk1("oe", 1'b1, oen);
        m.cyc(3'h2, 1'b0, 1'b0, 1'b1, 4'ha, 1'b1);
        chk4("lanes", 4'h5, lw);
        m.cyc(3'h2, 1'b0, 1'b1, 1'b1, LANES_NONE, 1'b0);
        chk1("write", 1'b0, wr);
        chk4("lanes", LANES_NONE, lw);
        chk1("oe", 1'b0, oen);
        $display("write test done");
    endtask : t_write
    task automatic t_burst;
        m.side(1'b0, 1'b1);
        m.cyc(3'h2, 1'b1, 1'b1, 1'b0, LANES_ALL, 1'b1);
        chk1("select", 1'b1, cs);
        chk4("lanes", LANES_ALL, lw);
        m.side(1'b1, 1'b0);
        m.cyc(3'h2, 1'b1, 1'b0, 1'b1, 4'h3, 1'b1);
        chk1("write", 1'b1, wr);
        chk4("lanes", 4'hc, lw);
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b1);
        chk1("write", 1'b0, wr);
        chk1("select", 1'b1, cs);
        m.side(1'b0, 1'b1);
        m.cyc(3'h5, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b1);
        chk1("select", 1'b0, cs);
        m.side(1'b1, 1'b1);
        $display("burst test done");
    endtask : t_burst
    task automatic t_select;
        for (int i = 0; i < 8; i++) begin
            m.cyc(i[2:0], 1'b0, 1'b1, 1'b1, LANES_ALL, 1'b1);
            chk1("select", i == 2, cs);
        end
        chk1("order", 1'b1, lin);
        $display("select test done");
    endtask : t_select
    task automatic t_sleep;
        m.cyc(3'h2, 1'b0, 1'b1, 1'b1, LANES_ALL, 1'b0);
        // two quiet cycles before the request
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b0);
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b0);
        chk1("valid", 1'b1, rv);
        m.zz(1'b1);
        chk1("select", 1'b0, cs);
        chk1("valid", 1'b0, rv);
        m.zz(1'b1);
        chk1("asleep", 1'b1, slp);
        chk1("clk_run", 1'b0, run);
        m.cyc(3'h2, 1'b0, 1'b1, 1'b0, LANES_NONE, 1'b1);
        chk1("write", 1'b0, wr);
        chk1("select", 1'b0, cs);
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b1);
        m.zz(1'b0);
        chk1("asleep", 1'b0, slp);
        chk1("clk_run", 1'b1, run);
        m.cyc(3'h2, 1'b1, 1'b1, 1'b1, LANES_ALL, 1'b1);
        m.cyc(3'h2, 1'b0, 1'b1, 1'b0, LANES_NONE, 1'b1);
        chk1("write", 1'b1, wr);
        $display("sleep test done");
    endtask : t_sleep
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    initial begin
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        chk1("oe", 1'b1, oen);
        chk1("clk_run", 1'b1, run);
        chk1("select", 1'b0, cs);
        chk1("write", 1'b0, wr);
        chk4("lanes", LANES_NONE, lw);
        chk1("asleep", 1'b0, slp);
        chk1("valid", 1'b0, rv);
        chk1("order", 1'b0, lin);
        rst_n = 1'b1;
        t_write;
        t_burst;
        t_select;
        t_sleep;
        conclude;
    end
endmodule : sync_sram_sleep_cycle_qualify_bench
